/* core/rss_alu.sv */
`timescale 1ns/1ns
module rss_alu
   import rss_pkg::*;
(
   rss_alu_if.alu  a
);

   wire        is_rl    = a.op == RSS_OP_ROT_L || a.op == RSS_OP_ROT_L_W;
   wire        is_rlt   = a.op == RSS_OP_ROT_LT || a.op == RSS_OP_ROT_LT_W;
   wire        is_rr    = a.op == RSS_OP_ROT_R || a.op == RSS_OP_ROT_R_W;
   wire        is_rrt   = a.op == RSS_OP_ROT_RT || a.op == RSS_OP_ROT_RT_W;
   wire        is_sbc   = a.op == RSS_OP_SUB_B || a.op == RSS_OP_SUB_B_M;
   wire        is_take  = a.op == RSS_OP_TAKE || a.op == RSS_OP_TAKE_M;
   wire        is_timm  = a.op == RSS_OP_TAKE_IMM;
   wire        is_dec   = a.op == RSS_OP_DEC_SK || a.op == RSS_OP_DEC_SK_W;
   wire        is_inc   = a.op == RSS_OP_INC_SK || a.op == RSS_OP_INC_SK_W;
   wire        is_set   = a.op == RSS_OP_SET_BYTE;
   wire        is_sbit  = a.op == RSS_OP_SET_BIT;
   wire        is_tbit  = a.op == RSS_OP_SKIP_BIT;
   wire        is_arith = is_sbc || is_take || is_timm;

   wire [7:0]  m        = a.mem_byte;
   wire [7:0]  sub_b    = is_timm ? ~a.imm_byte : ~m;
   wire        sub_cin  = is_sbc ? a.carry_in : 1'b1;
   wire [9:0]  sum      = rss_add(a.work_byte, sub_b, sub_cin);
   // Wraps modulo 256; the skip test sees only the low eight bits
   wire [7:0]  dec_val  = m - RSS_ONE;
   wire [7:0]  inc_val  = m + RSS_ONE;
   wire [7:0]  bit_mask = RSS_ONE << a.bit_sel;

   assign a.result =
      is_rl    ? {m[6:0], m[RSS_MSB]} :
      is_rlt   ? {m[6:0], a.carry_in} :
      is_rr    ? {m[0], m[RSS_MSB:1]} :
      is_rrt   ? {a.carry_in, m[RSS_MSB:1]} :
      is_arith ? sum[7:0] :
      is_dec   ? dec_val :
      is_inc   ? inc_val :
      is_set   ? RSS_ALL_ONES :
      is_sbit  ? (m | bit_mask) :
      m;

   assign a.carry_out = is_rlt ? m[RSS_MSB] :
                        is_rrt ? m[0] :
                        sum[8];
   assign a.half_out  = sum[9];
   // Signed wrap when both addends agree in sign and the sum does not
   assign a.wrap_out  = (a.work_byte[RSS_MSB] == sub_b[RSS_MSB]) &&
                        (sum[RSS_MSB] != a.work_byte[RSS_MSB]);
   assign a.zero_out  = rss_is_zero(sum[7:0]);

   assign a.upd_carry  = is_rlt || is_rrt;
   assign a.upd_arith  = is_arith;
   assign a.write_work = a.op == RSS_OP_ROT_L_W  ||
                         a.op == RSS_OP_ROT_LT_W ||
                         a.op == RSS_OP_ROT_R_W  ||
                         a.op == RSS_OP_ROT_RT_W ||
                         a.op == RSS_OP_SUB_B    ||
                         a.op == RSS_OP_TAKE     ||
                         is_timm                 ||
                         a.op == RSS_OP_DEC_SK_W ||
                         a.op == RSS_OP_INC_SK_W;
   assign a.write_mem  = a.op == RSS_OP_ROT_L    ||
                         a.op == RSS_OP_ROT_LT   ||
                         a.op == RSS_OP_ROT_R    ||
                         a.op == RSS_OP_ROT_RT   ||
                         a.op == RSS_OP_SUB_B_M  ||
                         a.op == RSS_OP_TAKE_M   ||
                         a.op == RSS_OP_DEC_SK   ||
                         a.op == RSS_OP_INC_SK   ||
                         is_set || is_sbit;
   assign a.skip = (is_dec && rss_is_zero(dec_val)) ||
                   (is_inc && rss_is_zero(inc_val)) ||
                   (is_tbit && m[a.bit_sel]);

endmodule

/* core/rss_datapath.sv */
`timescale 1ns/1ns
module rss_datapath
   import rss_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        op_valid,
   input  wire logic [4:0]  op_code,
   input  wire logic [2:0]  op_bit_sel,
   input  wire logic [7:0]  op_imm,
   output      logic        op_ready,
   input  wire logic [7:0]  mem_rdata,
   output      logic [7:0]  mem_wdata,
   output      logic        mem_we,
   output      logic        discard_fetch,
   output      logic [7:0]  work_register,
   output      logic        adder_out_flag,
   output      logic        half_nibble_out_flag,
   output      logic        zero_flag,
   output      logic        signed_wrap_flag,
   input  wire logic [1:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [7:0]  reg_rdata
);

   ////////////////////////////////////////////////////////////////////////
   // State and storage

   rss_state_t  state_reg;
   rss_state_t  state_next;
   logic [7:0]  work_reg;
   logic [7:0]  work_next;
   logic [3:0]  flags_reg;
   logic [3:0]  flags_next;
   logic [7:0]  wdata_reg;
   logic        we_reg;
   logic        discard_reg;
   logic [7:0]  skips_reg;
   logic [7:0]  rdata_reg;

   rss_alu_if   alu_bus ();

   rss_alu u_alu
   (
      .a (alu_bus.alu)
   );

   ////////////////////////////////////////////////////////////////////////
   // Issue and decode

   wire         in_exec  = state_reg == RSS_S_EXEC;
   // No new operation during the dummy cycle; the decoder must hold it
   assign op_ready = in_exec;
   wire         accept   = clk_en && op_valid && in_exec;

   assign alu_bus.op        = accept ? rss_op_t'(op_code) : RSS_OP_NONE;
   assign alu_bus.mem_byte  = mem_rdata;
   assign alu_bus.work_byte = work_reg;
   assign alu_bus.imm_byte  = op_imm;
   assign alu_bus.bit_sel   = op_bit_sel;
   assign alu_bus.carry_in  = flags_reg[RSS_F_CARRY];

   wire         take_skip = accept && alu_bus.skip;
   wire         wr_work   = reg_wr && reg_addr == RSS_ADDR_WORK;
   wire         wr_flags  = reg_wr && reg_addr == RSS_ADDR_FLAGS;

   ////////////////////////////////////////////////////////////////////////
   // Next values; an instruction result overrides a same-cycle port write

   wire [7:0]   work_base  = wr_work ? reg_wdata : work_reg;
   wire [3:0]   flags_base = wr_flags ? reg_wdata[3:0] : flags_reg;

   assign work_next = alu_bus.write_work ? alu_bus.result : work_base;

   wire         upd_c = alu_bus.upd_carry || alu_bus.upd_arith;
   // Flags outside these two groups are never touched by this block
   assign flags_next[RSS_F_CARRY] = upd_c ? alu_bus.carry_out
                                          : flags_base[RSS_F_CARRY];
   assign flags_next[RSS_F_HALF]  = alu_bus.upd_arith ? alu_bus.half_out
                                          : flags_base[RSS_F_HALF];
   assign flags_next[RSS_F_ZERO]  = alu_bus.upd_arith ? alu_bus.zero_out
                                          : flags_base[RSS_F_ZERO];
   assign flags_next[RSS_F_WRAP]  = alu_bus.upd_arith ? alu_bus.wrap_out
                                          : flags_base[RSS_F_WRAP];

   always_comb
   begin
      case (state_reg)
         RSS_S_EXEC:
            state_next = take_skip ? RSS_S_DUMMY : RSS_S_EXEC;
         RSS_S_DUMMY:
            state_next = RSS_S_EXEC;
         default:
            state_next = RSS_S_EXEC;
      endcase
   end

   wire [7:0]   rd_mux = reg_addr == RSS_ADDR_WORK  ? work_reg :
                         reg_addr == RSS_ADDR_FLAGS ? {4'h0, flags_reg} :
                         reg_addr == RSS_ADDR_SKIPS ? skips_reg :
                         RSS_ZERO;

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= RSS_S_EXEC;
         work_reg  <= RSS_WORK_RST;
         flags_reg <= RSS_FLAGS_RST;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         work_reg  <= work_next;
         flags_reg <= flags_next;
      end
   end

   // Memory write strobe lasts one enabled cycle after the instruction
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wdata_reg   <= RSS_ZERO;
         we_reg      <= 1'b0;
         discard_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         wdata_reg   <= alu_bus.result;
         we_reg      <= alu_bus.write_mem;
         discard_reg <= take_skip;
      end
   end

   // Counter wraps; software reads it to see how often skips were taken
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         skips_reg <= RSS_SKIPS_RST;
         rdata_reg <= RSS_ZERO;
      end
      else if (clk_en)
      begin
         if (take_skip)
            skips_reg <= skips_reg + RSS_ONE;
         if (reg_rd)
            rdata_reg <= rd_mux;
      end
   end

   assign mem_wdata            = wdata_reg;
   assign mem_we               = we_reg;
   assign discard_fetch        = discard_reg;
   assign work_register        = work_reg;
   assign adder_out_flag       = flags_reg[RSS_F_CARRY];
   assign half_nibble_out_flag = flags_reg[RSS_F_HALF];
   assign zero_flag            = flags_reg[RSS_F_ZERO];
   assign signed_wrap_flag     = flags_reg[RSS_F_WRAP];
   assign reg_rdata            = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   wire         go = accept && !reg_wr;

   function automatic logic is_op(input logic [4:0] code, input rss_op_t o);
      return code == o;
   endfunction

   property p_rot_left_work;
      go && is_op(op_code, RSS_OP_ROT_L_W) |=>
         work_reg == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} &&
         !we_reg && flags_reg == $past(flags_reg);
   endproperty
   a_rot_left_work: assert property (p_rot_left_work)
      else $error("rotate left to work wrong");

   property p_rot_left_thru;
      go && is_op(op_code, RSS_OP_ROT_LT) |=>
         we_reg && wdata_reg == {$past(mem_rdata[6:0]),
                                 $past(flags_reg[RSS_F_CARRY])} &&
         flags_reg[RSS_F_CARRY] == $past(mem_rdata[7]);
   endproperty
   a_rot_left_thru: assert property (p_rot_left_thru)
      else $error("rotate left through carry wrong");

   property p_rot_right_mem;
      go && is_op(op_code, RSS_OP_ROT_R) |=>
         we_reg && wdata_reg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
         && $stable(flags_reg);
   endproperty
   a_rot_right_mem: assert property (p_rot_right_mem)
      else $error("rotate right in memory wrong");

   property p_rot_right_thru_w;
      go && is_op(op_code, RSS_OP_ROT_RT_W) |=>
         !we_reg && work_reg == {$past(flags_reg[RSS_F_CARRY]),
                                 $past(mem_rdata[7:1])} &&
         flags_reg[RSS_F_CARRY] == $past(mem_rdata[0]);
   endproperty
   a_rot_right_thru_w: assert property (p_rot_right_thru_w)
      else $error("rotate right through to work wrong");

   property p_rot_left_thru_w;
      go && is_op(op_code, RSS_OP_ROT_LT_W) |=>
         !we_reg && work_reg == {$past(mem_rdata[6:0]),
                                 $past(flags_reg[RSS_F_CARRY])} &&
         flags_reg[RSS_F_CARRY] == $past(mem_rdata[7]);
   endproperty
   a_rot_left_thru_w: assert property (p_rot_left_thru_w)
      else $error("rotate left through to work wrong");

   property p_rot_right_thru;
      go && is_op(op_code, RSS_OP_ROT_RT) |=>
         we_reg && wdata_reg == {$past(flags_reg[RSS_F_CARRY]),
                                 $past(mem_rdata[7:1])} &&
         flags_reg[RSS_F_CARRY] == $past(mem_rdata[0]) &&
         flags_reg[RSS_F_WRAP:RSS_F_HALF] ==
            $past(flags_reg[RSS_F_WRAP:RSS_F_HALF]);
   endproperty
   a_rot_right_thru: assert property (p_rot_right_thru)
      else $error("rotate right through carry wrong");

   property p_sub_borrow;
      go && is_op(op_code, RSS_OP_SUB_B) |=>
         work_reg == ($past(work_reg) + ~$past(mem_rdata) +
                      {7'h00, $past(flags_reg[RSS_F_CARRY])}) &&
         flags_reg[RSS_F_ZERO] == (work_reg == RSS_ZERO);
   endproperty
   a_sub_borrow: assert property (p_sub_borrow)
      else $error("subtract with borrow wrong");

   property p_take_mem;
      go && is_op(op_code, RSS_OP_TAKE_M) |=>
         we_reg && $stable(work_reg) &&
         wdata_reg == ($past(work_reg) - $past(mem_rdata)) &&
         flags_reg[RSS_F_ZERO] == (wdata_reg == RSS_ZERO);
   endproperty
   a_take_mem: assert property (p_take_mem)
      else $error("take away to memory wrong");

   sequence s_skip_taken;
      accept && alu_bus.skip;
   endsequence

   // The dummy cycle ends only at an edge where the clock enable was high
   sequence s_dummy_then_ready;
      (!op_ready && discard_fetch) ##1
         ($past(clk_en) ? op_ready : !op_ready);
   endsequence

   property p_skip_two_cycles;
      s_skip_taken |=> s_dummy_then_ready;
   endproperty
   a_skip_two_cycles: assert property (p_skip_two_cycles)
      else $error("taken skip did not take two cycles");

   property p_no_skip_one_cycle;
      accept && !alu_bus.skip |=> op_ready && !discard_fetch;
   endproperty
   a_no_skip_one_cycle: assert property (p_no_skip_one_cycle)
      else $error("untaken skip stalled");

   property p_dec_skip;
      go && is_op(op_code, RSS_OP_DEC_SK) |=>
         we_reg && wdata_reg == ($past(mem_rdata) - RSS_ONE) &&
         discard_fetch == (wdata_reg == RSS_ZERO) && $stable(flags_reg);
   endproperty
   a_dec_skip: assert property (p_dec_skip)
      else $error("decrement skip wrong");

   property p_dec_skip_work;
      go && is_op(op_code, RSS_OP_DEC_SK_W) |=>
         !we_reg && work_reg == ($past(mem_rdata) - RSS_ONE) &&
         discard_fetch == (work_reg == RSS_ZERO) && $stable(flags_reg);
   endproperty
   a_dec_skip_work: assert property (p_dec_skip_work)
      else $error("decrement skip to work wrong");

   property p_set_byte;
      go && is_op(op_code, RSS_OP_SET_BYTE) |=>
         we_reg && wdata_reg == RSS_ALL_ONES && $stable(flags_reg);
   endproperty
   a_set_byte: assert property (p_set_byte)
      else $error("byte set wrong");

   property p_set_bit;
      go && is_op(op_code, RSS_OP_SET_BIT) |=>
         we_reg && wdata_reg == ($past(mem_rdata) |
                                 (RSS_ONE << $past(op_bit_sel)));
   endproperty
   a_set_bit: assert property (p_set_bit)
      else $error("bit set wrong");

   property p_inc_skip_work;
      go && is_op(op_code, RSS_OP_INC_SK_W) |=>
         !we_reg && work_reg == ($past(mem_rdata) + RSS_ONE) &&
         discard_fetch == ($past(mem_rdata) == RSS_ALL_ONES);
   endproperty
   a_inc_skip_work: assert property (p_inc_skip_work)
      else $error("increment skip to work wrong");

   wire         sel_bit = mem_rdata[op_bit_sel];

   property p_skip_bit;
      go && is_op(op_code, RSS_OP_SKIP_BIT) |=>
         !we_reg && $stable(flags_reg) && $stable(work_reg) &&
         discard_fetch == $past(sel_bit);
   endproperty
   a_skip_bit: assert property (p_skip_bit)
      else $error("skip if bit set wrong");

   property p_take_imm;
      go && is_op(op_code, RSS_OP_TAKE_IMM) |=>
         work_reg == ($past(work_reg) - $past(op_imm));
   endproperty
   a_take_imm: assert property (p_take_imm)
      else $error("immediate take away wrong");

   // A low clock enable must hold work, flags, state and skip count, port writes too
   property p_freeze;
      !clk_en |=> $stable(work_reg) && $stable(flags_reg) &&
                  $stable(state_reg) && $stable(skips_reg);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");

endmodule

/* inc/rss_alu_if.sv */
`timescale 1ns/1ns
interface rss_alu_if;
   import rss_pkg::*;
   rss_op_t     op;
   logic [7:0]  mem_byte;
   logic [7:0]  work_byte;
   logic [7:0]  imm_byte;
   logic [2:0]  bit_sel;
   logic        carry_in;
   logic [7:0]  result;
   logic        carry_out;
   logic        half_out;
   logic        wrap_out;
   logic        zero_out;
   logic        write_work;
   logic        write_mem;
   logic        upd_carry;
   logic        upd_arith;
   logic        skip;

   modport alu  (input  op, mem_byte, work_byte, imm_byte, bit_sel,
                        carry_in,
                 output result, carry_out, half_out, wrap_out, zero_out,
                        write_work, write_mem, upd_carry, upd_arith, skip);
   modport core (output op, mem_byte, work_byte, imm_byte, bit_sel,
                        carry_in,
                 input  result, carry_out, half_out, wrap_out, zero_out,
                        write_work, write_mem, upd_carry, upd_arith, skip);
endinterface

/* inc/rss_pkg.sv */
package rss_pkg;

   localparam int          RSS_W          = 8;
   localparam int          RSS_MSB        = 7;
   localparam int          RSS_NIB        = 4;
   localparam logic [7:0]  RSS_ALL_ONES   = 8'hFF;
   localparam logic [7:0]  RSS_ONE        = 8'h01;
   localparam logic [7:0]  RSS_ZERO       = 8'h00;
   localparam logic [7:0]  RSS_WORK_RST   = 8'h00;
   localparam logic [3:0]  RSS_FLAGS_RST  = 4'h0;
   localparam logic [7:0]  RSS_SKIPS_RST  = 8'h00;

   // Register port map
   localparam logic [1:0]  RSS_ADDR_WORK  = 2'h0;
   localparam logic [1:0]  RSS_ADDR_FLAGS = 2'h1;
   localparam logic [1:0]  RSS_ADDR_SKIPS = 2'h2;

   // Flag field positions
   localparam int          RSS_F_CARRY    = 0;
   localparam int          RSS_F_HALF     = 1;
   localparam int          RSS_F_ZERO     = 2;
   localparam int          RSS_F_WRAP     = 3;

   // Cycles per instruction
   localparam int          RSS_SKIP_CYC   = 2;
   localparam int          RSS_PLAIN_CYC  = 1;

   typedef enum logic [4:0]
   {
      RSS_OP_NONE      = 5'h00,
      RSS_OP_ROT_L_W   = 5'h01,
      RSS_OP_ROT_LT    = 5'h02,
      RSS_OP_ROT_LT_W  = 5'h03,
      RSS_OP_ROT_R     = 5'h04,
      RSS_OP_ROT_R_W   = 5'h05,
      RSS_OP_ROT_RT    = 5'h06,
      RSS_OP_ROT_RT_W  = 5'h07,
      RSS_OP_SUB_B     = 5'h08,
      RSS_OP_SUB_B_M   = 5'h09,
      RSS_OP_DEC_SK    = 5'h0A,
      RSS_OP_DEC_SK_W  = 5'h0B,
      RSS_OP_SET_BYTE  = 5'h0C,
      RSS_OP_SET_BIT   = 5'h0D,
      RSS_OP_INC_SK    = 5'h0E,
      RSS_OP_INC_SK_W  = 5'h0F,
      RSS_OP_SKIP_BIT  = 5'h10,
      RSS_OP_TAKE      = 5'h11,
      RSS_OP_TAKE_M    = 5'h12,
      RSS_OP_TAKE_IMM  = 5'h13,
      RSS_OP_ROT_L     = 5'h14
   } rss_op_t;

   typedef enum logic [0:0]
   {
      RSS_S_EXEC  = 1'b0,
      RSS_S_DUMMY = 1'b1
   } rss_state_t;

   // Returns {half_out, carry_out, sum}
   function automatic logic [9:0] rss_add(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       cin);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {low[4], full};
   endfunction

   function automatic logic rss_is_zero(input logic [7:0] v);
      return v == RSS_ZERO;
   endfunction

endpackage

/* verification/rss_mem_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// Data memory on the far side of the datapath, with a load port that
// stands in for the other instructions that fill memory.
module rss_mem_model
(
   input  wire logic        clk,
   input  wire logic [3:0]  addr,
   input  wire logic        ld_we,
   input  wire logic [7:0]  ld_data,
   input  wire logic        mem_we,
   input  wire logic [7:0]  mem_wdata,
   output      logic [7:0]  mem_rdata
);
   logic [7:0]  mem [16];

   // Read is combinational: the datapath samples it in the op cycle
   assign mem_rdata = mem[addr];

   // Result write lands at the edge closing the write cycle, same address
   always_ff @(posedge clk)
   begin
      if (mem_we)
         mem[addr] <= mem_wdata;
      else if (ld_we)
         mem[addr] <= ld_data;
   end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module tb_top;
   import rss_pkg::*;
   logic        clk, sys_rst, clk_en, op_valid, op_ready, mem_we;
   logic        discard_fetch, reg_wr, reg_rd, ld_we;
   logic        adder_out_flag, half_nibble_out_flag;
   logic        zero_flag, signed_wrap_flag;
   logic [4:0]  op_code;
   logic [2:0]  op_bit_sel;
   logic [1:0]  reg_addr;
   logic [3:0]  mem_addr;
   logic [7:0]  op_imm, mem_rdata, mem_wdata, work_register;
   logic [7:0]  reg_wdata, reg_rdata, ld_data, d, m, fl;
   // Reference state
   logic [7:0]  mw, mskips;
   logic        mc, mh, mz, mv;
   int          seed, bad_count, check_count, i;

   rss_datapath i_rss_datapath (.clk(clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
      .op_bit_sel(op_bit_sel), .op_imm(op_imm), .op_ready(op_ready),
      .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .discard_fetch(discard_fetch), .work_register(work_register),
      .adder_out_flag(adder_out_flag),
      .half_nibble_out_flag(half_nibble_out_flag),
      .zero_flag(zero_flag), .signed_wrap_flag(signed_wrap_flag),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   rss_mem_model i_rss_mem_model (.clk(clk), .addr(mem_addr),
      .ld_we(ld_we), .ld_data(ld_data), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      if (bad_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data appear in the cycle after the strobe and hold until the next read
   task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   task automatic arith(input logic [7:0] b, input logic ci,
                        output logic [7:0] r);
      logic [8:0]  s;
      int          lo;
      s = {1'b0, mw} + {1'b0, b} + {8'h00, ci};
      lo = mw[3:0] + b[3:0] + ci;
      r = s[7:0];
      mv = (mw[7] == b[7]) && (r[7] != mw[7]);
      mc = s[8];
      mh = (lo > 15);
      mz = (r == 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Load the byte, issue the op, then check result cycle and next cycle
   task automatic run_op(input logic [4:0] op, input logic [3:0] a,
                         input logic [7:0] mv_in, input logic [2:0] bs,
                         input logic [7:0] imm);
      logic [7:0]  r;
      logic        dw, dm, sk;
      @(posedge clk);
      mem_addr <= a;
      ld_data <= mv_in;
      ld_we <= 1'b1;
      @(posedge clk);
      ld_we <= 1'b0;
      op_valid <= 1'b1;
      op_code <= op;
      op_bit_sel <= bs;
      op_imm <= imm;
      @(posedge clk);
      op_valid <= 1'b0;
      r = mv_in;
      sk = 1'b0;
      dm = op inside {RSS_OP_ROT_L, RSS_OP_ROT_LT, RSS_OP_ROT_R,
         RSS_OP_ROT_RT, RSS_OP_SUB_B_M, RSS_OP_DEC_SK, RSS_OP_SET_BYTE,
         RSS_OP_SET_BIT, RSS_OP_INC_SK, RSS_OP_TAKE_M};
      dw = op inside {RSS_OP_ROT_L_W, RSS_OP_ROT_LT_W, RSS_OP_ROT_R_W,
         RSS_OP_ROT_RT_W, RSS_OP_SUB_B, RSS_OP_DEC_SK_W, RSS_OP_INC_SK_W,
         RSS_OP_TAKE, RSS_OP_TAKE_IMM};
      case (op)
         RSS_OP_ROT_L_W, RSS_OP_ROT_L: r = {mv_in[6:0], mv_in[7]};
         RSS_OP_ROT_LT, RSS_OP_ROT_LT_W: {mc, r} = {mv_in, mc};
         RSS_OP_ROT_R, RSS_OP_ROT_R_W: r = {mv_in[0], mv_in[7:1]};
         RSS_OP_ROT_RT, RSS_OP_ROT_RT_W: {r, mc} = {mc, mv_in};
         RSS_OP_SUB_B, RSS_OP_SUB_B_M: arith(~mv_in, mc, r);
         RSS_OP_DEC_SK, RSS_OP_DEC_SK_W: r = mv_in - 8'h01;
         RSS_OP_INC_SK, RSS_OP_INC_SK_W: r = mv_in + 8'h01;
         RSS_OP_SET_BYTE: r = 8'hFF;
         RSS_OP_SET_BIT: r = mv_in | (8'h01 << bs);
         RSS_OP_SKIP_BIT: sk = mv_in[bs];
         RSS_OP_TAKE, RSS_OP_TAKE_M: arith(~mv_in, 1'b1, r);
         RSS_OP_TAKE_IMM: arith(~imm, 1'b1, r);
         default: r = mv_in;
      endcase
      if (op inside {RSS_OP_DEC_SK, RSS_OP_DEC_SK_W, RSS_OP_INC_SK,
                     RSS_OP_INC_SK_W})
         sk = (r == 8'h00);
      if (dw)
         mw = r;
      mskips = mskips + {7'h00, sk};
      #1;
      check({7'h00, mem_we}, {7'h00, dm});
      if (dm)
         check(mem_wdata, r);
      check(work_register, mw);
      check({4'h0, signed_wrap_flag, zero_flag, half_nibble_out_flag,
             adder_out_flag}, {4'h0, mv, mz, mh, mc});
      check({6'h00, discard_fetch, op_ready}, {6'h00, sk, !sk});
      @(posedge clk);
      #1;
      check(mem_rdata, dm ? r : mv_in);
      check({7'h00, op_ready}, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 62;
      bad_count = 0;
      check_count = 0;
      {sys_rst, clk_en} = 2'b11;
      {op_valid, reg_wr, reg_rd, ld_we} = 4'h0;
      {op_code, op_bit_sel, reg_addr, mem_addr} = 14'h0000;
      {op_imm, reg_wdata, ld_data} = 24'h000000;
      {mw, mskips, mc, mh, mz, mv} = 20'h00000;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      reg_read(RSS_ADDR_WORK, RSS_WORK_RST);
      reg_read(RSS_ADDR_FLAGS, {4'h0, RSS_FLAGS_RST});
      reg_read(RSS_ADDR_SKIPS, RSS_SKIPS_RST);
      reg_write(2'h3, 8'hA5);
      reg_read(2'h3, 8'h00);
      // Wrap boundaries: the first two must skip, 00 decremented to FF must not
      run_op(RSS_OP_DEC_SK, 4'h1, 8'h01, 3'h0, 8'h00);
      run_op(RSS_OP_INC_SK_W, 4'h2, 8'hFF, 3'h0, 8'h00);
      run_op(RSS_OP_DEC_SK_W, 4'h3, 8'h00, 3'h0, 8'h00);
      for (i = 0; i < 400; i++)
      begin
         if (i % 4 == 0)
         begin
            fl = 8'($random(seed));
            reg_write(RSS_ADDR_FLAGS, fl);
            {mv, mz, mh, mc} = fl[3:0];
         end
         if (i % 8 == 1)
         begin
            d = 8'($random(seed));
            reg_write(RSS_ADDR_WORK, d);
            mw = d;
         end
         m = 8'($random(seed));
         if (i % 3 == 0)
            m = (i % 9 == 0) ? 8'h00 : ((i % 9 == 3) ? 8'h01 : 8'hFF);
         run_op(5'(i % 22), 4'($random(seed)), m,
                3'($random(seed)), 8'($random(seed)));
      end
      // Taken skip with the clock enable dropped in its dummy cycle; a
      // port write made while frozen must be lost
      @(posedge clk);
      mem_addr <= 4'h5;
      ld_data <= RSS_ONE;
      ld_we <= 1'b1;
      @(posedge clk);
      ld_we <= 1'b0;
      op_valid <= 1'b1;
      op_code <= RSS_OP_DEC_SK;
      @(posedge clk);
      op_valid <= 1'b0;
      clk_en <= 1'b0;
      reg_addr <= RSS_ADDR_WORK;
      reg_wdata <= ~mw;
      reg_wr <= 1'b1;
      mskips = mskips + 8'h01;
      repeat (3) @(posedge clk);
      #1;
      check({6'h00, discard_fetch, op_ready}, 8'h02);
      check(mem_wdata, RSS_ZERO);
      @(posedge clk);
      clk_en <= 1'b1;
      reg_wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check({6'h00, discard_fetch, op_ready}, 8'h01);
      check(work_register, mw);
      check(mem_rdata, RSS_ZERO);
      reg_read(RSS_ADDR_SKIPS, mskips);
      reg_write(RSS_ADDR_SKIPS, 8'h5A);
      reg_read(RSS_ADDR_SKIPS, mskips);
      reg_read(RSS_ADDR_FLAGS, {4'h0, mv, mz, mh, mc});
      reg_read(RSS_ADDR_WORK, mw);
      summarize;
   end

   // A hang ends the run through the same report
   initial
   begin
      repeat (100000) @(posedge clk);
      bad_count++;
      summarize;
   end
endmodule
